// *** pct_agent.sv ***
// agent end: enters test mode, applies patterns, captures, exits
// assumes the device end on the same clock through pct_if
`timescale 1ns/10ps
`default_nettype none
`include "pct_defs.svh"
module pct_agent
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // system state
  input  wire logic        power_good,
  input  wire logic        dev_initialized,
  // user commands
  input  wire logic        start_req,
  input  wire logic        stop_req,
  input  wire logic        capture_req,
  input  wire pct_tin_s    pattern,
  // user results
  output logic             in_test,
  output logic             refused,
  output logic             result_valid,
  output pct_tout_s        result,
  // pins
  pct_if.agent             pins
);

  typedef enum logic [2:0] {
    PCT_IDLE   = 3'b000,
    PCT_ENTER  = 3'b001,
    PCT_READY  = 3'b010,
    PCT_SETTLE = 3'b011,
    PCT_RESET  = 3'b100
  } pct_astate_e;

  // wait covers both the sample delay and the output settle time
  localparam int WAIT_I = (`PCT_SAMPLE_CYC > `PCT_SETTLE_CYC) ?
    `PCT_SAMPLE_CYC : `PCT_SETTLE_CYC;
  localparam logic [`PCT_CNT_W-1:0] WAIT_CYC = `PCT_CNT_W'(WAIT_I + 1);
  localparam logic [`PCT_CNT_W-1:0] SET_CYC = `PCT_CNT_W'(`PCT_SETTLE_CYC);
  localparam logic [`PCT_CNT_W-1:0] RST_CYC = `PCT_CNT_W'(`PCT_RST_HOLD_CYC);

  pct_astate_e           state_r;
  logic [`PCT_CNT_W-1:0] cnt_r;
  pct_tin_s              tin_r;

  // sequencer: entry checks, hold times and the closing reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PCT_IDLE;
      cnt_r   <= '0;
    end else begin
      cnt_r <= cnt_r + `PCT_CNT_W'(1);
      case (state_r)
        PCT_IDLE: begin
          cnt_r <= '0;
          if (start_req && power_good && !dev_initialized) begin
            state_r <= PCT_ENTER;
          end
        end
        PCT_ENTER: begin
          if (stop_req) begin
            state_r <= PCT_RESET;
            cnt_r   <= '0;
          end else if (cnt_r == WAIT_CYC) begin
            state_r <= PCT_READY;
          end
        end
        PCT_READY: begin
          cnt_r <= '0;
          if (stop_req) begin
            state_r <= PCT_RESET;
          end else if (capture_req) begin
            state_r <= PCT_SETTLE;
          end
        end
        PCT_SETTLE: begin
          if (cnt_r == SET_CYC) begin
            state_r <= PCT_READY;
          end
        end
        PCT_RESET: begin
          if (cnt_r == RST_CYC) begin
            state_r <= PCT_IDLE;
          end
        end
        default: state_r <= PCT_IDLE;
      endcase
    end
  end

  // pattern register; entry drives cke high and clocks quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tin_r     <= '0;
      tin_r.cke <= 1'b1;
    end else if (state_r == PCT_READY && capture_req) begin
      tin_r <= pattern;
    end else if (state_r == PCT_IDLE) begin
      tin_r     <= '0;
      tin_r.cke <= 1'b1;
    end
  end

  // capture after the settle time; pulses one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state_r == PCT_SETTLE && cnt_r == SET_CYC) begin
        result.dq    <= pins.dq_o & ~pins.dq_oe_n;
        result.lst   <= pins.lower_strobe_true & ~pins.strobe_oe_n[0];
        result.lsc   <= pins.lower_strobe_comp & ~pins.strobe_oe_n[0];
        result.ust   <= pins.upper_strobe_true & ~pins.strobe_oe_n[1];
        result.usc   <= pins.upper_strobe_comp & ~pins.strobe_oe_n[1];
        result_valid <= 1'b1;
      end
    end
  end

  // refusal of a start that power-on or initialisation forbids
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused <= 1'b0;
    end else begin
      refused <= start_req && (state_r != PCT_IDLE || !power_good
                 || dev_initialized);
    end
  end

  // pins: reset pin high through the whole test, low only to reset
  assign pins.continuity_mode_pin = (state_r == PCT_ENTER)
    || (state_r == PCT_READY) || (state_r == PCT_SETTLE);
  assign pins.device_reset_low = (state_r != PCT_RESET);
  assign pins.chip_select_low  = (state_r == PCT_IDLE)
    || (state_r == PCT_ENTER) || (state_r == PCT_RESET);
  assign pins.tin = tin_r;
  assign in_test  = pins.continuity_mode_pin;

endmodule
`default_nettype wire

// *** pct_chk.sv ***
// assertions on the continuity test pins between agent and device
// assumes an x16 device without the A17 term and one clock domain
`timescale 1ns/10ps
`default_nettype none
module pct_chk
  import pct_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // agent side
  input wire logic        continuity_mode_pin,
  input wire logic        device_reset_low,
  input wire logic        chip_select_low,
  input wire pct_tin_s    tin,
  // device side
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe_n,
  input wire logic        lower_strobe_true,
  input wire logic        lower_strobe_comp,
  input wire logic        upper_strobe_true,
  input wire logic        upper_strobe_comp,
  input wire logic [1:0]  strobe_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [1:0] mode_hist_r;
  logic       live;

  // two cycles of history keep the normal path out of the lane checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_hist_r <= 2'h0;
    end else begin
      mode_hist_r <= {mode_hist_r[0], continuity_mode_pin};
    end
  end
  assign live = (&mode_hist_r) & continuity_mode_pin & !chip_select_low & !dq_oe_n[0];

  chk_cs_gate: assert property (
    continuity_mode_pin && mode_hist_r[0] && chip_select_low |-> (&dq_oe_n) && (&strobe_oe_n))
    else $error("test outputs driven while chip select high");
  chk_lane0_term: assert property (
    live |-> dq_o[0] == (tin.addr[1] ^ tin.addr[6] ^ tin.par))
    else $error("lane 0 wrong");
  chk_lane2_term: assert property (
    live |-> dq_o[2] == (tin.addr[2] ^ tin.addr[5] ^ tin.addr[13]))
    else $error("lane 2 wrong");
  chk_lane3_term: assert property (
    live |-> dq_o[3] == (tin.addr[0] ^ tin.addr[7] ^ tin.addr[11]))
    else $error("lane 3 wrong");
  chk_lane6_term: assert property (
    live |-> dq_o[6] == (tin.act_n ^ tin.addr[4] ^ tin.ba[1]))
    else $error("lane 6 wrong");
  chk_lower_strobes: assert property (
    live |-> lower_strobe_true == (tin.addr[14] ^ tin.addr[12] ^ tin.ba[0])
      && lower_strobe_comp == !(tin.bg[0] ^ tin.addr[3]))
    else $error("lower strobes wrong");
  chk_upper_inv: assert property (
    live && !dq_oe_n[8] |-> dq_o[15:8] == ~dq_o[7:0]
      && upper_strobe_true != lower_strobe_true && upper_strobe_comp != lower_strobe_comp)
    else $error("upper half not inverse of lower");
  chk_enter_reset: assert property (
    $rose(continuity_mode_pin) |-> device_reset_low)
    else $error("mode entered with reset pin low");
  chk_sample_wait: assert property (
    $rose(continuity_mode_pin) |-> ##2 (&dq_oe_n) [*2])
    else $error("lanes driven before sample delay");
  chk_exit_reset: assert property (
    $fell(continuity_mode_pin) |-> !device_reset_low && chip_select_low ##1 !device_reset_low [*8])
    else $error("no full reset after exit");
endmodule
`default_nettype wire

// *** pct_defs.svh ***
// timing and sizing constants for the pin continuity test ends
// assumes a single 40 MHz clock feeding both ends
//
// Behaviour
// - ten xor minterms from test input pins
// - mode pin high means test, low normal
// - outputs driven only while chip select low
// - x4 lanes are xor of minterm pairs
// - x8 lanes copy minterms zero to seven
// - x16 lower lanes and strobes copy minterms
// - x16 upper lanes invert the lower ones
// - agent enters only with reset pin high
// - clock pins become test inputs after switch
// - other inputs sampled after delay, chip select
// - no refresh of any kind in test mode
// - agent enters only after power-on, uninitialised
// - exit anytime; array content then undefined; the agent ignores stop_req while in PCT_SETTLE
// - agent applies full reset after exit
// - outputs settle within settle time while held
`ifndef PCT_DEFS_SVH
`define PCT_DEFS_SVH

`define PCT_CLK_PERIOD_NS 25
// clock_input_switch_time, a longest time
`define PCT_SWITCH_NS     200
// input_sample_delay, a least time
`define PCT_SAMPLE_NS     100
// output_settle_time, a longest time for the device
`define PCT_SETTLE_NS     50
// full reset pulse the agent applies after exit
`define PCT_RST_HOLD_NS   1000

`define PCT_CYC_DN(t) (((t) / `PCT_CLK_PERIOD_NS) < 1 ? 1 : ((t) / `PCT_CLK_PERIOD_NS))
`define PCT_CYC_UP(t) (((t) + `PCT_CLK_PERIOD_NS - 1) / `PCT_CLK_PERIOD_NS)

`define PCT_SWITCH_CYC   `PCT_CYC_DN(`PCT_SWITCH_NS)
`define PCT_SAMPLE_CYC   `PCT_CYC_UP(`PCT_SAMPLE_NS)
`define PCT_SETTLE_CYC   `PCT_CYC_DN(`PCT_SETTLE_NS)
`define PCT_RST_HOLD_CYC `PCT_CYC_UP(`PCT_RST_HOLD_NS)

`define PCT_CNT_W 8
`define PCT_CNT_MAX 8'hFF

`endif

// *** pct_device.sv ***
// device end: continuity test output logic plus mode tracking
// assumes pins synchronous to clk; normal-path logic sits outside
`timescale 1ns/10ps
`default_nettype none
`include "pct_defs.svh"
module pct_device
  import pct_pkg::*;
#(
  parameter pct_width_e DEV_WIDTH = PCT_X16,
  parameter bit         USE_A17   = 1'b0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // pins
  pct_if.dev               pins,
  // normal-path drive from the memory core
  input  wire logic [15:0] normal_dq_o,
  input  wire logic [15:0] normal_dq_oe_n,
  input  wire logic [3:0]  normal_strobe_o,
  input  wire logic [1:0]  normal_strobe_oe_n,
  // refresh requests from the core
  input  wire logic        auto_refresh_req,
  input  wire logic        self_refresh_req,
  // status towards the core
  output logic             test_mode,
  output logic             cmd_decode_en,
  output logic             auto_refresh_grant,
  output logic             self_refresh_grant,
  output logic             clocks_as_inputs,
  output logic             sample_enabled,
  output logic             array_undefined
);

  typedef enum logic [1:0] {
    PCT_NORMAL = 2'b00,
    PCT_TEST   = 2'b01,
    PCT_EXITED = 2'b10
  } pct_dstate_e;

  localparam logic [`PCT_CNT_W-1:0] SW_CYC =
    `PCT_CNT_W'(`PCT_SWITCH_CYC);
  localparam logic [`PCT_CNT_W-1:0] SMP_CYC =
    `PCT_CNT_W'(`PCT_SAMPLE_CYC);

  pct_dstate_e             state_r;
  pct_dstate_e             state_nxt;
  logic [`PCT_CNT_W-1:0]   cnt_r;
  logic                    ck_test_r;
  logic                    entry_ok_r;
  logic [9:0]              mt;
  logic [15:0]             test_dq;
  logic [15:0]             lane_used;
  logic [3:0]              test_strobe;
  logic                    drive_en;

  // ten minterms; clock terms count only once clocks became test inputs
  function automatic logic [9:0] minterms(input pct_tin_s t,
                                          input logic ck_en,
                                          input logic rst_pin,
                                          input logic mode_pin);
    logic [9:0] m;
    logic       ckt;
    logic       ckc;
    m   = 10'h000;
    ckt = t.ck_t & ck_en;
    ckc = t.ck_c & ck_en;
    m[0] = t.addr[1] ^ t.addr[6] ^ t.par;
    m[1] = t.addr[8] ^ t.alert_n ^ t.addr[9];
    m[2] = t.addr[2] ^ t.addr[5] ^ t.addr[13]
         ^ (t.addr[17] & USE_A17);
    m[3] = t.addr[0] ^ t.addr[7] ^ t.addr[11];
    m[4] = ckc ^ t.odt ^ t.addr[15];
    m[5] = t.cke ^ t.addr[16] ^ t.addr[10];
    m[6] = t.act_n ^ t.addr[4] ^ t.ba[1];
    case (DEV_WIDTH)
      PCT_X16: m[7] = t.dm_u_n ^ t.dm_l_n ^ ckt;
      PCT_X8:  m[7] = t.bg[1] ^ t.dm_l_n ^ ckt;
      default: m[7] = t.bg[1] ^ ckt;
    endcase
    m[8] = t.addr[14] ^ t.addr[12] ^ t.ba[0];
    m[9] = t.bg[0] ^ t.addr[3] ^ (rst_pin & mode_pin);
    return m;
  endfunction

  // lane mapping per width; strobes are {usc, ust, lsc, lst}
  function automatic logic [19:0] lanes(input logic [9:0] m);
    logic [15:0] d;
    logic [3:0]  s;
    d = 16'h0000;
    s = 4'h0;
    case (DEV_WIDTH)
      PCT_X4: begin
        d[0] = m[0] ^ m[1];
        d[1] = m[2] ^ m[3];
        d[2] = m[4] ^ m[5];
        d[3] = m[6] ^ m[7];
        s    = {2'b00, m[9], m[8]};
      end
      PCT_X8: begin
        d[7:0] = m[7:0];
        s      = {2'b00, m[9], m[8]};
      end
      default: begin
        d[7:0]  = m[7:0];
        d[15:8] = ~m[7:0];
        s[1:0]  = {m[9], m[8]};
        s[3:2]  = ~{m[9], m[8]};
      end
    endcase
    return {s, d};
  endfunction

  // which pins a given width owns; the rest stay released
  function automatic logic [15:0] used_lanes(input pct_width_e w);
    logic [15:0] u;
    case (w)
      PCT_X4:  u = 16'h000F;
      PCT_X8:  u = 16'h00FF;
      default: u = 16'hFFFF;
    endcase
    return u;
  endfunction

  // mode follows the pin; an exit leaves the array suspect until reset pin
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PCT_NORMAL: begin
        if (pins.continuity_mode_pin) begin
          state_nxt = PCT_TEST;
        end
      end
      PCT_TEST: begin
        if (!pins.continuity_mode_pin) begin
          state_nxt = PCT_EXITED;
        end
      end
      PCT_EXITED: begin
        if (pins.continuity_mode_pin) begin
          state_nxt = PCT_TEST;
        end else if (!pins.device_reset_low) begin
          state_nxt = PCT_NORMAL;
        end
      end
      default: state_nxt = PCT_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PCT_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycles since the mode pin rose, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt != PCT_TEST) begin
      cnt_r <= '0;
    end else if (cnt_r != `PCT_CNT_MAX) begin
      cnt_r <= cnt_r + `PCT_CNT_W'(1);
    end
  end

  // entry conditions are judged on the rising cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_ok_r <= 1'b0;
    end else if (state_r != PCT_TEST && state_nxt == PCT_TEST) begin
      entry_ok_r <= pins.device_reset_low & pins.tin.cke
                    & pins.chip_select_low;
    end else if (state_nxt != PCT_TEST) begin
      entry_ok_r <= 1'b0;
    end
  end

  // clock pins join the test inputs once the switch time has run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_test_r <= 1'b0;
    end else if (state_nxt != PCT_TEST) begin
      ck_test_r <= 1'b0;
    end else if (entry_ok_r && cnt_r >= SW_CYC - `PCT_CNT_W'(1)) begin
      ck_test_r <= 1'b1;
    end
  end

  // test path has no flops, so it settles well inside the settle time
  always_comb begin
    mt        = minterms(pins.tin, ck_test_r, pins.device_reset_low,
                         pins.continuity_mode_pin);
    {test_strobe, test_dq} = lanes(mt);
    lane_used = used_lanes(DEV_WIDTH);
  end

  assign test_mode        = (state_r == PCT_TEST);
  assign sample_enabled   = test_mode && cnt_r >= SMP_CYC;
  assign clocks_as_inputs = ck_test_r;
  assign drive_en         = sample_enabled && !pins.chip_select_low;
  assign array_undefined  = (state_r == PCT_EXITED);

  // normal decode and refresh are both shut off while testing
  assign cmd_decode_en      = !test_mode;
  assign auto_refresh_grant = auto_refresh_req && !test_mode;
  assign self_refresh_grant = self_refresh_req && !test_mode;

  // pin mux: test results replace the normal drive in test mode
  always_comb begin
    if (test_mode) begin
      pins.dq_o    = test_dq & lane_used;
      pins.dq_oe_n = ~(lane_used & {16{drive_en}});
      pins.lower_strobe_true = test_strobe[0];
      pins.lower_strobe_comp = test_strobe[1];
      pins.upper_strobe_true = test_strobe[2];
      pins.upper_strobe_comp = test_strobe[3];
      pins.strobe_oe_n[0] = !drive_en;
      pins.strobe_oe_n[1] = !(drive_en && DEV_WIDTH == PCT_X16);
    end else begin
      pins.dq_o    = normal_dq_o;
      pins.dq_oe_n = normal_dq_oe_n;
      pins.lower_strobe_true = normal_strobe_o[0];
      pins.lower_strobe_comp = normal_strobe_o[1];
      pins.upper_strobe_true = normal_strobe_o[2];
      pins.upper_strobe_comp = normal_strobe_o[3];
      pins.strobe_oe_n = normal_strobe_oe_n;
    end
  end

endmodule
`default_nettype wire

// *** pct_if.sv ***
// pin bundle between the test agent and the memory device
// two-way pins appear as output and active-low enable only
`timescale 1ns/10ps
`default_nettype none
interface pct_if;
  import pct_pkg::*;

  logic        continuity_mode_pin;
  logic        device_reset_low;
  logic        chip_select_low;
  pct_tin_s    tin;
  logic [15:0] dq_o;
  logic [15:0] dq_oe_n;
  logic        lower_strobe_true;
  logic        lower_strobe_comp;
  logic        upper_strobe_true;
  logic        upper_strobe_comp;
  logic [1:0]  strobe_oe_n;

  modport dev (
    input  continuity_mode_pin, device_reset_low, chip_select_low, tin,
    output dq_o, dq_oe_n, lower_strobe_true, lower_strobe_comp,
    output upper_strobe_true, upper_strobe_comp, strobe_oe_n
  );

  modport agent (
    output continuity_mode_pin, device_reset_low, chip_select_low, tin,
    input  dq_o, dq_oe_n, lower_strobe_true, lower_strobe_comp,
    input  upper_strobe_true, upper_strobe_comp, strobe_oe_n
  );
endinterface
`default_nettype wire

// *** pct_pkg.sv ***
// types shared by both ends of the continuity test link
// assumes pct_defs.svh for the numeric constants
`default_nettype none
package pct_pkg;

  // device data width option
  typedef enum logic [1:0] {
    PCT_X4  = 2'b00,
    PCT_X8  = 2'b01,
    PCT_X16 = 2'b10
  } pct_width_e;

  // parallel test inputs; command names are their address aliases
  typedef struct packed {
    logic [17:0] addr;
    logic [1:0]  ba;
    logic [1:0]  bg;
    logic        act_n;
    logic        odt;
    logic        par;
    logic        alert_n;
    logic        dm_l_n;
    logic        dm_u_n;
    logic        cke;
    logic        ck_t;
    logic        ck_c;
  } pct_tin_s;

  // test outputs as the agent captures them
  typedef struct packed {
    logic [15:0] dq;
    logic        lst;
    logic        lsc;
    logic        ust;
    logic        usc;
  } pct_tout_s;

endpackage
`default_nettype wire

// *** pin_continuity_test_logic_tb_top.sv ***
// bench joining agent and x16 device; drives the agent user side
// assumes the design files compiled first and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pin_continuity_test_logic_tb_top;
  import pct_pkg::*;
  logic      clk, rst_n, power_good, dev_initialized, start_req, stop_req, capture_req;
  logic      in_test, refused, result_valid, auto_refresh_req, self_refresh_req;
  logic      test_mode, cmd_decode_en, auto_refresh_grant, self_refresh_grant;
  logic      clocks_as_inputs, sample_enabled, array_undefined;
  pct_tin_s  pattern;
  pct_tout_s result;
  int        failures, num_checks, cycles;

  pct_if link ();
  // normal path tied to a fixed drive so mode changes show at the pins
  pct_device #(.DEV_WIDTH(PCT_X16), .USE_A17(1'b0)) pct_device_i (
    .clk(clk), .rst_n(rst_n), .pins(link), .normal_dq_o(16'hA5C3),
    .normal_dq_oe_n(16'h0000), .normal_strobe_o(4'hA), .normal_strobe_oe_n(2'h0),
    .auto_refresh_req(auto_refresh_req), .self_refresh_req(self_refresh_req),
    .test_mode(test_mode), .cmd_decode_en(cmd_decode_en),
    .auto_refresh_grant(auto_refresh_grant), .self_refresh_grant(self_refresh_grant),
    .clocks_as_inputs(clocks_as_inputs), .sample_enabled(sample_enabled),
    .array_undefined(array_undefined));
  pct_agent pct_agent_i (
    .clk(clk), .rst_n(rst_n), .power_good(power_good), .dev_initialized(dev_initialized),
    .start_req(start_req), .stop_req(stop_req), .capture_req(capture_req),
    .pattern(pattern), .in_test(in_test), .refused(refused),
    .result_valid(result_valid), .result(result), .pins(link));
  pct_chk pct_chk_i (
    .clk(clk), .rst_n(rst_n), .continuity_mode_pin(link.continuity_mode_pin),
    .device_reset_low(link.device_reset_low), .chip_select_low(link.chip_select_low),
    .tin(link.tin), .dq_o(link.dq_o), .dq_oe_n(link.dq_oe_n),
    .lower_strobe_true(link.lower_strobe_true), .lower_strobe_comp(link.lower_strobe_comp),
    .upper_strobe_true(link.upper_strobe_true), .upper_strobe_comp(link.upper_strobe_comp),
    .strobe_oe_n(link.strobe_oe_n));
  // narrow devices see the same agent pins, so x4 and x8 lanes get checked too
  pct_if link4 ();
  pct_if link8 ();
  assign link4.continuity_mode_pin = link.continuity_mode_pin;
  assign link4.device_reset_low    = link.device_reset_low;
  assign link4.chip_select_low     = link.chip_select_low;
  assign link4.tin                 = link.tin;
  assign link8.continuity_mode_pin = link.continuity_mode_pin;
  assign link8.device_reset_low    = link.device_reset_low;
  assign link8.chip_select_low     = link.chip_select_low;
  assign link8.tin                 = link.tin;
  pct_device #(.DEV_WIDTH(PCT_X4), .USE_A17(1'b0)) pct_device_x4_i (
    .clk(clk), .rst_n(rst_n), .pins(link4), .normal_dq_o(16'h0000),
    .normal_dq_oe_n(16'hFFFF), .normal_strobe_o(4'h0), .normal_strobe_oe_n(2'h3),
    .auto_refresh_req(1'b0), .self_refresh_req(1'b0), .test_mode(), .cmd_decode_en(),
    .auto_refresh_grant(), .self_refresh_grant(), .clocks_as_inputs(),
    .sample_enabled(), .array_undefined());
  pct_device #(.DEV_WIDTH(PCT_X8), .USE_A17(1'b0)) pct_device_x8_i (
    .clk(clk), .rst_n(rst_n), .pins(link8), .normal_dq_o(16'h0000),
    .normal_dq_oe_n(16'hFFFF), .normal_strobe_o(4'h0), .normal_strobe_oe_n(2'h3),
    .auto_refresh_req(1'b0), .self_refresh_req(1'b0), .test_mode(), .cmd_decode_en(),
    .auto_refresh_grant(), .self_refresh_grant(), .clocks_as_inputs(),
    .sample_enabled(), .array_undefined());

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard, far above the roughly 250 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  // expected outputs for the given width worked out from the test inputs
  function automatic pct_tout_s expect_out(input pct_tin_s t, input pct_width_e w);
    logic [9:0] m;
    pct_tout_s  r;
    m[0] = t.addr[1] ^ t.addr[6] ^ t.par;
    m[1] = t.addr[8] ^ t.alert_n ^ t.addr[9];
    m[2] = t.addr[2] ^ t.addr[5] ^ t.addr[13];
    m[3] = t.addr[0] ^ t.addr[7] ^ t.addr[11];
    m[4] = t.ck_c ^ t.odt ^ t.addr[15];
    m[5] = t.cke ^ t.addr[16] ^ t.addr[10];
    m[6] = t.act_n ^ t.addr[4] ^ t.ba[1];
    case (w)
      PCT_X16: m[7] = t.dm_u_n ^ t.dm_l_n ^ t.ck_t;
      PCT_X8:  m[7] = t.bg[1] ^ t.dm_l_n ^ t.ck_t;
      default: m[7] = t.bg[1] ^ t.ck_t;
    endcase
    m[8] = t.addr[14] ^ t.addr[12] ^ t.ba[0];
    m[9] = t.bg[0] ^ t.addr[3] ^ 1'b1;
    // lanes a width does not own read back as zero
    r = '0;
    r.lst = m[8];
    r.lsc = m[9];
    case (w)
      PCT_X16: begin
        r.dq = {~m[7:0], m[7:0]};
        r.ust = ~m[8];
        r.usc = ~m[9];
      end
      PCT_X8: begin
        r.dq[7:0] = m[7:0];
      end
      default: begin
        r.dq[3:0] = {m[6] ^ m[7], m[4] ^ m[5], m[2] ^ m[3], m[0] ^ m[1]};
      end
    endcase
    return r;
  endfunction

  task automatic start_try(input logic ok);
    @(posedge clk) start_req <= 1'b1;
    @(posedge clk) start_req <= 1'b0;
    @(negedge clk);
    `CHK("refused", !ok, refused)
    `CHK("in_test", ok, in_test)
  endtask

  task automatic capture(input pct_tin_s p);
    pct_tout_s e;
    pct_tout_s e4;
    pct_tout_s e8;
    e  = expect_out(p, PCT_X16);
    e4 = expect_out(p, PCT_X4);
    e8 = expect_out(p, PCT_X8);
    @(posedge clk) begin
      capture_req <= 1'b1;
      pattern <= p;
    end
    @(posedge clk) capture_req <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 20 && result_valid !== 1'b1; i++) @(negedge clk);
    `CHK("result_valid", 1'b1, result_valid)
    `CHK("result", e, result)
    `CHK("dq pins", e.dq, link.dq_o)
    `CHK("dq enables", 16'h0000, link.dq_oe_n)
    `CHK("strobe enables", 2'h0, link.strobe_oe_n)
    `CHK("x4 lanes", e4.dq, link4.dq_o)
    `CHK("x4 strobe true", e4.lst, link4.lower_strobe_true)
    `CHK("x4 strobe comp", e4.lsc, link4.lower_strobe_comp)
    `CHK("x4 enables", {16'hFFF0, 2'h2}, {link4.dq_oe_n, link4.strobe_oe_n})
    `CHK("x8 lanes", e8.dq, link8.dq_o)
    `CHK("x8 strobe true", e8.lst, link8.lower_strobe_true)
    `CHK("x8 strobe comp", e8.lsc, link8.lower_strobe_comp)
    `CHK("x8 enables", {16'hFF00, 2'h2}, {link8.dq_oe_n, link8.strobe_oe_n})
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence: refusals, entry, pattern sweep, exit and reset
  initial begin
    {rst_n, power_good, start_req, stop_req, capture_req} = 5'h00;
    {dev_initialized, auto_refresh_req, self_refresh_req} = 3'h7;
    pattern = '0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("normal dq", 16'hA5C3, link.dq_o)
    `CHK("refresh grant", 1'b1, auto_refresh_grant)
    `CHK("self refresh grant", 1'b1, self_refresh_grant)
    `CHK("normal decode", 1'b1, cmd_decode_en)
    start_try(1'b0);
    @(posedge clk) dev_initialized <= 1'b0;
    start_try(1'b0);
    @(posedge clk) power_good <= 1'b1;
    start_try(1'b1);
    for (int i = 0; i < 100 && link.chip_select_low !== 1'b0; i++) @(negedge clk);
    `CHK("test_mode", 1'b1, test_mode)
    `CHK("decode", 1'b0, cmd_decode_en)
    `CHK("auto grant", 1'b0, auto_refresh_grant)
    `CHK("self grant", 1'b0, self_refresh_grant)
    repeat (10) @(negedge clk);
    `CHK("clocks", 1'b1, clocks_as_inputs)
    `CHK("sampling", 1'b1, sample_enabled)
    capture(pct_tin_s'(31'h0000_0000));
    for (int i = 0; i < 31; i++) capture(pct_tin_s'(31'h1 << i));
    capture(pct_tin_s'(31'h7FFF_FFFF));
    @(posedge clk) stop_req <= 1'b1;
    @(posedge clk) stop_req <= 1'b0;
    @(negedge clk);
    `CHK("exit mode", 1'b0, in_test)
    `CHK("reset pin", 1'b0, link.device_reset_low)
    for (int i = 0; i < 5 && array_undefined !== 1'b1; i++) @(negedge clk);
    `CHK("array undefined", 1'b1, array_undefined)
    for (int i = 0; i < 60 && link.device_reset_low !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    `CHK("reset released", 1'b1, link.device_reset_low)
    `CHK("normal again", 16'hA5C3, link.dq_o)
    `CHK("refresh back", 1'b1, auto_refresh_grant)
    test_done();
  end
endmodule
`default_nettype wire
